// file: hdl/rms_cfg.svh
/*
 Timing and framing constants for the radio mode and enable sequencer.
 Assumes a 25 MHz controller clock; times are given in their own units.
*/
`ifndef RMS_CFG_SVH
`define RMS_CFG_SVH

`define RMS_CLK_MHZ          25
`define RMS_PLL_SETTLE_US    10
`define RMS_TRIM_MIN_US      100
`define RMS_TRIM_STORE_US    10
`define RMS_TX_LOCK_US       25
`define RMS_TX_RAMP_US       2
`define RMS_RX_FIRST_US      700
`define RMS_RX_QUICK_US      7
`define RMS_HOLD_MS          1000
`define RMS_TRIM_PERIOD_MS   1000
`define RMS_PREAMBLE_BITS    8
`define RMS_HALF_BIT_CYC     3
`define RMS_RX_MID_MIN_CYC   4

`endif

// file: hdl/rms_pkg.sv
/*
 Types shared by the sequencer and its line encoder.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rms_pkg;

   typedef enum logic [3:0] {
      ST_IDLE        = 4'h0,
      ST_TRIM_SETTLE = 4'h1,
      ST_TRIM_RUN    = 4'h2,
      ST_TRIM_STORE  = 4'h3,
      ST_TX_LOCK     = 4'h4,
      ST_TX_RAMP     = 4'h5,
      ST_TX_SEND     = 4'h6,
      ST_RX_WAKE     = 4'h7,
      ST_RX_ON       = 4'h8
   } rms_state_e;

   typedef struct packed {
      logic rx_en;
      logic tx_en;
      logic pll_en;
      logic trim_en;
      logic gnd_sw;
   } rms_pins_s;

endpackage : rms_pkg

// file: hdl/rms_manch_tx.sv
/*
 Manchester line encoder: one data bit in, two half-bit symbols out.
 Assumes bit source on the same clock; line rests low when idle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rms_cfg.svh"

module rms_manch_tx
   import rms_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic bit_valid,
   input  wire logic bit_val,
   output wire logic bit_ready,
   output var  logic busy,
   output var  logic tx_out
);

   localparam logic [1:0] HALF_LAST = 2'(`RMS_HALF_BIT_CYC - 1);

   logic       half_r;
   logic [1:0] cnt_r;
   logic       cur_r;
   wire        end_bit;
   wire        load;

   // Ready in the last cycle of a bit so bits follow with no gap
   assign end_bit   = busy & half_r & (cnt_r == HALF_LAST);
   assign bit_ready = ~busy | end_bit;
   assign load      = bit_valid & bit_ready;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy   <= 1'b0;
         half_r <= 1'b0;
         cnt_r  <= 2'h0;
         cur_r  <= 1'b0;
         tx_out <= 1'b0;
      end else if (ce) begin
         if (load) begin
            busy   <= 1'b1;
            half_r <= 1'b0;
            cnt_r  <= 2'h0;
            cur_r  <= bit_val;
            tx_out <= bit_val;  // RULE15
         end else if (busy) begin
            if (cnt_r == HALF_LAST) begin
               cnt_r <= 2'h0;
               if (half_r) begin
                  busy   <= 1'b0;
                  tx_out <= 1'b0;  // RULE7
               end else begin
                  half_r <= 1'b1;
                  tx_out <= ~cur_r;  // RULE15
               end
            end else begin
               cnt_r <= cnt_r + 2'h1;
            end
         end
      end
   end

endmodule : rms_manch_tx
`default_nettype wire

// file: hdl/rms_seq_ctrl.sv
/*
 Baseband-side controller that sequences the enable pins of a 2.4 GHz AM
 transceiver: VCO trim, transmit bursts with preamble, and receive.
 Assumes user requests on REF_CLK; RX_DATA_PIN arrives asynchronously.
*/
// What this block does
// RULE1 - All enables low puts the radio in standby; idle drives them all low.
// RULE2 - Receive enable powers the receiver chain.
// RULE3 - Transmit enable powers the transmit chain.
// RULE4 - Synthesizer enable powers the synthesizer and oscillator.
// RULE5 - Input ground switch grounds the receiver input while transmitting.
// RULE6 - Raise ground switch and synthesizer before transmit enable.
// RULE7 - Hold transmit data low while the transmit chain powers up.
// RULE8 - Synthesizer on, wait 10 us, then raise calibration request.
// RULE9 - Hold calibration request for at least 100 us.
// RULE10 - After calibration request falls keep synthesizer on for 10 us.
// RULE11 - Synthesizer on during calibration and transmit, off while receiving.
// RULE12 - Receiver valid 700 us after first enable, 7 us while charge held.
// RULE13 - Each burst starts with at least eight preamble bits.
// RULE14 - Recalibrate every one to ten seconds or on request.
// RULE15 - Controller Manchester-encodes transmit and decodes receive data.
// RULE16 - Never transmit and receive enable together; release one first.
`timescale 1ns/10ps
`default_nettype none
`include "rms_cfg.svh"

module rms_seq_ctrl
   import rms_pkg::*;
#(
   parameter int RX_FIRST_CYC    = `RMS_RX_FIRST_US * `RMS_CLK_MHZ,
   parameter int HOLD_CYC        = `RMS_HOLD_MS * 1000 * `RMS_CLK_MHZ,
   parameter int TRIM_PERIOD_CYC = `RMS_TRIM_PERIOD_MS * 1000 * `RMS_CLK_MHZ
)
(
   input  wire logic       REF_CLK,
   input  wire logic       RESETN,
   input  wire logic       CE,
   input  wire logic       USE_GND_SW,
   input  wire logic       REQ_TRIM,
   input  wire logic       REQ_TX,
   input  wire logic       REQ_RX,
   input  wire logic       REQ_STOP,
   input  wire logic [7:0] TX_BYTE,
   input  wire logic       TX_VALID,
   input  wire logic       TX_LAST,
   output var  logic       TX_READY,
   output var  logic       RX_BIT,
   output var  logic       RX_BIT_VALID,
   output var  logic       RX_LIVE,
   output var  logic [3:0] SEQ_STATE,
   input  wire logic       RX_DATA_PIN,
   output wire logic       RX_EN,
   output wire logic       TX_EN,
   output wire logic       PLL_EN,
   output wire logic       TRIM_EN,
   output wire logic       INPUT_GROUND_SWITCH,
   output wire logic       TX_DATA
);

   localparam int CW = 25;
   localparam int SETTLE_CYC = `RMS_PLL_SETTLE_US * `RMS_CLK_MHZ;
   localparam int TRIM_CYC   = `RMS_TRIM_MIN_US * `RMS_CLK_MHZ;
   localparam int STORE_CYC  = `RMS_TRIM_STORE_US * `RMS_CLK_MHZ;
   localparam int LOCK_CYC   = `RMS_TX_LOCK_US * `RMS_CLK_MHZ;
   localparam int RAMP_CYC   = `RMS_TX_RAMP_US * `RMS_CLK_MHZ;
   localparam int QUICK_CYC  = `RMS_RX_QUICK_US * `RMS_CLK_MHZ;
   localparam logic [3:0] PRE_BITS = 4'(`RMS_PREAMBLE_BITS);
   localparam logic [2:0] MID_MIN  = 3'(`RMS_RX_MID_MIN_CYC);

   rms_state_e      state_r, state_nxt;
   rms_pins_s       pins_r, pins_nxt;
   logic [CW-1:0]   cnt_r, cnt_nxt;
   logic [CW-1:0]   hold_r;
   logic [CW-1:0]   per_r;
   logic            charged_r, trim_due_r, tx_pend_r, rx_pend_r, stop_pend_r;
   logic            last_r;
   logic [3:0]      pre_left_r, bits_left_r;
   logic [7:0]      shreg_r;
   logic            rx_s1, rx_s2, rx_s3;
   logic [2:0]      gap_r;
   logic            enc_ready, enc_busy;

   wire cnt_done  = (cnt_r == '0);
   wire in_idle   = (state_r == ST_IDLE);
   wire in_rx     = (state_r == ST_RX_WAKE) || (state_r == ST_RX_ON);
   wire sending   = (state_r == ST_TX_SEND);
   wire trim_go   = trim_due_r || REQ_TRIM;
   wire go_tx     = in_idle && !trim_go && tx_pend_r;
   wire go_rx     = in_idle && !trim_go && !tx_pend_r && rx_pend_r;
   wire enc_valid = sending && ((pre_left_r != 4'h0) || (bits_left_r != 4'h0));
   wire enc_bit   = (pre_left_r != 4'h0) ? ~pre_left_r[0] : shreg_r[7];
   wire enc_take  = enc_valid && enc_ready;
   wire pre_take  = enc_take && (pre_left_r != 4'h0);
   wire dat_take  = enc_take && (pre_left_r == 4'h0);
   wire byte_take = TX_VALID && TX_READY;
   wire tx_done   = last_r && !enc_valid && !enc_busy;
   wire rx_edge   = rx_s2 ^ rx_s3;
   wire rx_mid    = rx_edge && (gap_r >= MID_MIN);

   // Sequencing of the enable lines
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_done ? cnt_r : cnt_r - CW'(1);
      case (state_r)
         ST_IDLE: begin
            if (trim_go) begin
               state_nxt = ST_TRIM_SETTLE;
               cnt_nxt   = CW'(SETTLE_CYC - 1);  // RULE8
            end else if (tx_pend_r) begin
               state_nxt = ST_TX_LOCK;
               cnt_nxt   = CW'(LOCK_CYC - 1);  // RULE6
            end else if (rx_pend_r) begin
               state_nxt = ST_RX_WAKE;
               cnt_nxt   = charged_r ? CW'(QUICK_CYC - 1) : CW'(RX_FIRST_CYC - 1);  // RULE12
            end
         end
         ST_TRIM_SETTLE: if (cnt_done) begin
            state_nxt = ST_TRIM_RUN;
            cnt_nxt   = CW'(TRIM_CYC - 1);  // RULE9
         end
         ST_TRIM_RUN: if (cnt_done) begin
            state_nxt = ST_TRIM_STORE;
            cnt_nxt   = CW'(STORE_CYC - 1);  // RULE10
         end
         ST_TRIM_STORE: if (cnt_done) state_nxt = ST_IDLE;
         ST_TX_LOCK: if (cnt_done) begin
            state_nxt = ST_TX_RAMP;
            cnt_nxt   = CW'(RAMP_CYC - 1);  // RULE7
         end
         ST_TX_RAMP: if (cnt_done) state_nxt = ST_TX_SEND;
         ST_TX_SEND: if (tx_done) state_nxt = ST_IDLE;
         ST_RX_WAKE: begin
            if (stop_pend_r || trim_due_r) state_nxt = ST_IDLE;
            else if (cnt_done) state_nxt = ST_RX_ON;
         end
         ST_RX_ON: if (stop_pend_r || trim_due_r) state_nxt = ST_IDLE;  // RULE14
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Pin levels follow the next state; one state at a time, so RX_* and TX_* enables never both
   always_comb begin
      pins_nxt         = '0;  // RULE1
      pins_nxt.rx_en   = (state_nxt == ST_RX_WAKE) || (state_nxt == ST_RX_ON);  // RULE2 RULE16
      pins_nxt.tx_en   = (state_nxt == ST_TX_RAMP) || (state_nxt == ST_TX_SEND);  // RULE3 RULE16
      pins_nxt.pll_en  = (state_nxt == ST_TRIM_SETTLE) || (state_nxt == ST_TRIM_RUN) ||
                         (state_nxt == ST_TRIM_STORE) || (state_nxt == ST_TX_LOCK) ||
                         (state_nxt == ST_TX_RAMP) || (state_nxt == ST_TX_SEND);  // RULE4 RULE11
      pins_nxt.trim_en = (state_nxt == ST_TRIM_RUN);  // RULE8 RULE9
      pins_nxt.gnd_sw  = USE_GND_SW && ((state_nxt == ST_TX_LOCK) ||
                         (state_nxt == ST_TX_RAMP) || (state_nxt == ST_TX_SEND));  // RULE5 RULE6
   end

   assign RX_EN               = pins_r.rx_en;
   assign TX_EN               = pins_r.tx_en;
   assign PLL_EN              = pins_r.pll_en;
   assign TRIM_EN             = pins_r.trim_en;
   assign INPUT_GROUND_SWITCH = pins_r.gnd_sw;

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r   <= ST_IDLE;
         pins_r    <= '0;
         cnt_r     <= '0;
         SEQ_STATE <= 4'h0;
         RX_LIVE   <= 1'b0;
      end else if (CE) begin
         state_r   <= state_nxt;
         pins_r    <= pins_nxt;
         cnt_r     <= cnt_nxt;
         SEQ_STATE <= state_nxt;
         RX_LIVE   <= (state_nxt == ST_RX_ON);
      end
   end

   // Requests: a new request in the cycle it is taken stays pending
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_pend_r   <= 1'b0;
         rx_pend_r   <= 1'b0;
         stop_pend_r <= 1'b0;
         trim_due_r  <= 1'b1;  // Untrimmed VCO after power-up
         per_r       <= '0;
      end else if (CE) begin
         tx_pend_r   <= REQ_TX | (tx_pend_r & ~go_tx);
         rx_pend_r   <= REQ_RX | (rx_pend_r & ~go_rx);
         stop_pend_r <= REQ_STOP | (stop_pend_r & in_rx);
         if (in_idle && trim_go) begin
            trim_due_r <= 1'b0;
            per_r      <= '0;
         end else begin
            // A request seen outside idle is kept, so a busy radio is still trimmed
            if (REQ_TRIM || (per_r == CW'(TRIM_PERIOD_CYC - 1))) begin
               trim_due_r <= 1'b1;  // RULE14
            end
            if (per_r != CW'(TRIM_PERIOD_CYC - 1)) begin
               per_r <= per_r + CW'(1);
            end
         end
      end
   end

   // Demodulator charge is assumed lost once the receiver stays off too long
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         charged_r <= 1'b0;
         hold_r    <= '0;
      end else if (CE) begin
         if (pins_r.rx_en) begin
            hold_r <= '0;
            if (state_r == ST_RX_ON) charged_r <= 1'b1;  // RULE12
         end else if (hold_r == CW'(HOLD_CYC - 1)) begin
            charged_r <= 1'b0;  // RULE12
         end else begin
            hold_r <= hold_r + CW'(1);
         end
      end
   end

   // Burst feed: preamble first, then user bytes MSB first
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pre_left_r  <= 4'h0;
         bits_left_r <= 4'h0;
         shreg_r     <= 8'h00;
         last_r      <= 1'b0;
         TX_READY    <= 1'b0;
      end else if (CE) begin
         if (!sending) begin
            pre_left_r  <= PRE_BITS;  // RULE13
            bits_left_r <= 4'h0;
            last_r      <= 1'b0;
         end else if (byte_take) begin
            shreg_r     <= TX_BYTE;
            bits_left_r <= 4'h8;
            last_r      <= TX_LAST;
         end else if (pre_take) begin
            pre_left_r <= pre_left_r - 4'h1;  // RULE13
         end else if (dat_take) begin
            shreg_r     <= {shreg_r[6:0], 1'b0};
            bits_left_r <= bits_left_r - 4'h1;
         end
         TX_READY <= (state_nxt == ST_TX_SEND) && sending && !byte_take && !last_r &&
                     (pre_left_r == 4'h0) && ((bits_left_r == 4'h0) ||
                     (bits_left_r == 4'h1 && dat_take));
      end
   end

   rms_manch_tx u_enc (
      .clk       (REF_CLK),
      .rst_n     (RESETN),
      .ce        (CE),
      .bit_valid (enc_valid),
      .bit_val   (enc_bit),
      .bit_ready (enc_ready),
      .busy      (enc_busy),
      .tx_out    (TX_DATA)
   );

   // Receive decoder: a transition far enough from the last mid-bit one is mid-bit
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_s1        <= 1'b0;
         rx_s2        <= 1'b0;
         rx_s3        <= 1'b0;
         gap_r        <= 3'h7;
         RX_BIT       <= 1'b0;
         RX_BIT_VALID <= 1'b0;
      end else if (CE) begin
         rx_s1        <= RX_DATA_PIN;
         rx_s2        <= rx_s1;
         rx_s3        <= rx_s2;
         RX_BIT_VALID <= 1'b0;
         if (rx_mid) begin
            gap_r <= 3'h1;
            if (state_r == ST_RX_ON) begin
               RX_BIT       <= ~rx_s2;  // RULE15
               RX_BIT_VALID <= 1'b1;
            end
         end else if (gap_r != 3'h7) begin
            gap_r <= gap_r + 3'h1;
         end
      end
   end

endmodule : rms_seq_ctrl
`default_nettype wire

// file: testbench/rms_seq_ctrl_asserts.sv
/*
 Concurrent checks on the enable pins driven by the sequencer.
 Assumes a 25 MHz REF_CLK; bound onto every rms_seq_ctrl instance.
*/
`timescale 1ns/10ps
`default_nettype none
module rms_seq_ctrl_asserts
   import rms_pkg::*;
#(
   parameter int RX_FIRST_CYC = 17500
)
(
   input wire logic       REF_CLK,
   input wire logic       RESETN,
   input wire logic       USE_GND_SW,
   input wire logic       RX_EN,
   input wire logic       TX_EN,
   input wire logic       PLL_EN,
   input wire logic       TRIM_EN,
   input wire logic       INPUT_GROUND_SWITCH,
   input wire logic       TX_DATA,
   input wire logic       RX_LIVE,
   input wire logic [3:0] SEQ_STATE
);
   localparam int RX_MIN = (RX_FIRST_CYC < 175) ? RX_FIRST_CYC : 175;
   logic [15:0] pll_cnt_r, trim_cnt_r, rx_cnt_r;

   // Saturating run length, so a long receive cannot wrap back to a small count
   function automatic logic [15:0] run(input logic [15:0] c, input logic en);
      return en ? c + {15'h0000, c != 16'hFFFF} : 16'h0000;
   endfunction : run

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pll_cnt_r  <= 16'h0000;
         trim_cnt_r <= 16'h0000;
         rx_cnt_r   <= 16'h0000;
      end else begin
         pll_cnt_r  <= run(pll_cnt_r, PLL_EN);
         trim_cnt_r <= run(trim_cnt_r, TRIM_EN);
         rx_cnt_r   <= run(rx_cnt_r, RX_EN);
      end
   end

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);

   chk_no_overlap: assert property (!(TX_EN && RX_EN))
      else $error("transmit and receive enables high together");
   chk_idle_standby: assert property (
      SEQ_STATE == 4'h0 |-> {RX_EN, TX_EN, PLL_EN, TRIM_EN, INPUT_GROUND_SWITCH} == 5'h00)
      else $error("enable left high in idle");
   chk_trim_settle: assert property ($rose(TRIM_EN) |-> pll_cnt_r >= 16'h00FA)
      else $error("trim request before synthesizer settled");
   chk_trim_length: assert property ($fell(TRIM_EN) |-> trim_cnt_r >= 16'h09C4)
      else $error("trim request too short");
   chk_store_hold: assert property ($fell(TRIM_EN) |-> PLL_EN throughout (##240 1'b1))
      else $error("synthesizer dropped during trim store");
   chk_tx_lock: assert property (
      $rose(TX_EN) |-> pll_cnt_r >= 16'h0271 && INPUT_GROUND_SWITCH == USE_GND_SW)
      else $error("transmit enable before lock or switch");
   chk_tx_ramp: assert property ($rose(TX_EN) |-> !TX_DATA throughout (##45 1'b1))
      else $error("transmit data high during ramp");
   chk_synth_need: assert property (TX_EN || TRIM_EN |-> PLL_EN)
      else $error("synthesizer off during trim or transmit");
   chk_rx_synth_off: assert property (RX_EN |-> !PLL_EN)
      else $error("synthesizer on while receiving");
   chk_rx_wake: assert property ($rose(RX_LIVE) |-> RX_EN && rx_cnt_r >= RX_MIN)
      else $error("receiver declared live too early");
endmodule : rms_seq_ctrl_asserts

bind rms_seq_ctrl rms_seq_ctrl_asserts #(.RX_FIRST_CYC(RX_FIRST_CYC)) rms_seq_ctrl_asserts_i (
   .REF_CLK(REF_CLK), .RESETN(RESETN), .USE_GND_SW(USE_GND_SW), .RX_EN(RX_EN),
   .TX_EN(TX_EN), .PLL_EN(PLL_EN), .TRIM_EN(TRIM_EN), .INPUT_GROUND_SWITCH(INPUT_GROUND_SWITCH),
   .TX_DATA(TX_DATA), .RX_LIVE(RX_LIVE), .SEQ_STATE(SEQ_STATE));
`default_nettype wire

// file: testbench/rms_radio_model.sv
/*
 Behavioural radio on the far side of the enable pins.
 Assumes the controller clock as time base; all counts are in its cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module rms_radio_model
   import rms_pkg::*;
#(
   parameter int FIRST_CYC = 50,
   parameter int QUICK_CYC = 175,
   parameter int HOLD_CYC  = 2000,
   parameter int STORE_CYC = 240
)
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire rms_pins_s pins,
   input  wire logic      air,
   output var  logic      standby,
   output var  logic      tx_on,
   output var  logic      lna_gnd,
   output var  logic      rx_valid,
   output var  logic      trim_ok,
   output var  logic      rx_data
);
   int   wake_r, off_r, store_r;
   logic fast_r, junk_r;

   always_comb begin
      standby  = pins == 5'h00;
      tx_on    = pins.tx_en;
      lna_gnd  = pins.gnd_sw;
      rx_valid = pins.rx_en && wake_r >= (fast_r ? QUICK_CYC : FIRST_CYC);
      // An unsettled receiver shows a toggling line, never a stale level
      rx_data  = rx_valid ? air : junk_r;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_r  <= 0;
         off_r   <= HOLD_CYC;
         store_r <= 0;
         fast_r  <= 1'b0;
         junk_r  <= 1'b0;
         trim_ok <= 1'b0;
      end else begin
         junk_r <= ~junk_r;
         wake_r <= pins.rx_en ? wake_r + 1 : 0;
         if (pins.rx_en && wake_r == 0) begin
            fast_r <= off_r < HOLD_CYC;
         end
         off_r <= pins.rx_en ? 0 : (off_r < HOLD_CYC ? off_r + 1 : off_r);
         if (pins.trim_en && pins.pll_en) begin
            store_r <= STORE_CYC;
            trim_ok <= 1'b0;
         end else if (store_r > 0) begin
            store_r <= pins.pll_en ? store_r - 1 : 0;
            trim_ok <= pins.pll_en && store_r == 1;
         end
      end
   end
endmodule : rms_radio_model
`default_nettype wire

// file: testbench/tb.sv
/*
 Self-checking bench: sequencer against the behavioural radio.
 Assumes scaled wake, hold and trim-period counts to keep the run short.
*/
`timescale 1ns/10ps
`default_nettype none
module tb
   import rms_pkg::*;
;
   logic       clk, rst_n, ce, gnd, req_trim, req_tx, req_rx, req_stop, tx_valid, tx_last, air;
   logic [7:0] tx_byte;
   wire        tx_ready, rx_bit, rx_bit_valid, rx_live, rx_en, tx_en, pll_en, trim_en;
   wire        gnd_sw, tx_data, rx_pin, standby, tx_on, lna_gnd, rx_valid, trim_ok;
   wire  [3:0] state;
   rms_pins_s  pins;
   int         n_mismatch = 0;
   int         compares = 0;
   int         en_run = 0;
   logic       rxq[$];

   assign pins = {rx_en, tx_en, pll_en, trim_en, gnd_sw};
   rms_seq_ctrl #(.RX_FIRST_CYC(50), .HOLD_CYC(2000), .TRIM_PERIOD_CYC(20000)) rms_seq_ctrl_i (
      .REF_CLK(clk), .RESETN(rst_n), .CE(ce), .USE_GND_SW(gnd), .REQ_TRIM(req_trim),
      .REQ_TX(req_tx), .REQ_RX(req_rx), .REQ_STOP(req_stop), .TX_BYTE(tx_byte),
      .TX_VALID(tx_valid), .TX_LAST(tx_last), .TX_READY(tx_ready), .RX_BIT(rx_bit),
      .RX_BIT_VALID(rx_bit_valid), .RX_LIVE(rx_live), .SEQ_STATE(state), .RX_DATA_PIN(rx_pin),
      .RX_EN(rx_en), .TX_EN(tx_en), .PLL_EN(pll_en), .TRIM_EN(trim_en),
      .INPUT_GROUND_SWITCH(gnd_sw), .TX_DATA(tx_data));
   rms_radio_model rms_radio_model_i (.clk(clk), .rst_n(rst_n), .pins(pins), .air(air),
      .standby(standby), .tx_on(tx_on), .lna_gnd(lna_gnd), .rx_valid(rx_valid),
      .trim_ok(trim_ok), .rx_data(rx_pin));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Cycles the receive enable has stood, independent of when a task looks
   always @(posedge clk) begin
      en_run <= (rx_en === 1'b1) ? en_run + 1 : 0;
      if (rx_bit_valid === 1'b1) begin
         rxq.push_back(rx_bit);
      end
   end

   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, e, s);
      end
   endtask : chk

   task automatic wait_st(input logic [3:0] s, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (state !== s && n < 20000);
      chk("state", 8'(s), 8'(state));
   endtask : wait_st

   task automatic t_trim();
      int n;
      wait_st(4'h2, n);
      chk("trim_start", 8'h01, 8'(n >= 250 && n <= 260));
      @(posedge clk) ce <= 1'b0;
      repeat (10) @(negedge clk);
      chk("frozen", 8'h12, {3'h0, trim_en, state});
      @(posedge clk) ce <= 1'b1;
      wait_st(4'h0, n);
      chk("trim_stored", 8'h11, {3'h0, trim_ok, 3'h0, standby});
   endtask : t_trim

   task automatic t_tx(input logic g);
      logic [23:0] exp;
      int          i, j, k;
      logic        h1;
      exp = {8'hAA, 8'hC3, 8'h5A};
      j = 0;
      @(posedge clk);
      gnd <= g;
      req_tx <= 1'b1;
      req_rx <= g;
      tx_byte <= 8'hC3;
      tx_valid <= 1'b1;
      tx_last <= 1'b0;
      @(posedge clk);
      req_tx <= 1'b0;
      req_rx <= 1'b0;
      fork
         for (k = 0; k < 2; k++) begin
            do @(negedge clk); while (tx_ready !== 1'b1 && ++j < 3000);
            @(posedge clk);
            tx_byte <= 8'h5A;
            tx_last <= 1'b1;
            tx_valid <= (k == 0);
         end
         begin
            i = 0;
            do @(negedge clk); while (tx_data !== 1'b1 && ++i < 3000);
            chk("tx_pins", {5'h00, g, 2'h3}, {5'h00, lna_gnd, tx_on, pll_en});
            for (i = 23; i >= 0; i--) begin
               h1 = tx_data;
               repeat (3) @(negedge clk);
               chk("tx_bit", {6'h00, exp[i], ~exp[i]}, {6'h00, h1, tx_data});
               repeat (3) @(negedge clk);
            end
         end
      join
      repeat (3) @(negedge clk);
      chk("tx_off", 8'h00, {6'h00, tx_en, tx_data});
      if (!g) chk("standby", 8'h01, {7'h00, standby});
   endtask : t_tx

   task automatic t_rx(input int wake, input logic trm);
      logic [15:0] frame;
      logic [7:0]  got;
      int          n, i;
      frame = {8'hAA, 8'hB4};
      got = 8'h00;
      wait_st(4'h7, n);
      wait_st(4'h8, n);
      chk("rx_wake", 8'h01, 8'(en_run >= wake - 1 && en_run <= wake + 2));
      repeat (2) @(negedge clk);
      chk("rx_ready", 8'h03, {5'h00, pll_en, rx_valid, rx_live});
      rxq.delete();
      for (i = 15; i >= 0; i--) begin
         repeat (3) @(posedge clk);
         air <= frame[i];
         repeat (3) @(posedge clk);
         air <= ~frame[i];
      end
      repeat (3) @(posedge clk);
      air <= 1'b0;
      repeat (12) @(negedge clk);
      foreach (rxq[j]) got = {got[6:0], rxq[j]};
      chk("rx_byte", 8'hB4, got);
      chk("rx_count", 8'h01, 8'(rxq.size() >= 8));
      @(posedge clk);
      req_stop <= 1'b1;
      req_trim <= trm;
      @(posedge clk);
      req_stop <= 1'b0;
      req_trim <= 1'b0;
   endtask : t_rx

   task automatic wrap_up();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      $display("MISMATCH watchdog expected finish seen hang");
      wrap_up();
   end

   initial begin
      {rst_n, req_trim, req_tx, req_rx, req_stop, tx_valid, tx_last, air} = 8'h00;
      {ce, gnd} = 2'h3;
      tx_byte = 8'h00;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_trim();
      t_tx(1'b1);
      t_rx(50, 1'b0);
      t_tx(1'b0);
      @(posedge clk) req_rx <= 1'b1;
      @(posedge clk) req_rx <= 1'b0;
      t_rx(175, 1'b1);
      t_trim();
      wrap_up();
   end
endmodule : tb
`default_nettype wire
